/* rtl/smps_pkg.sv */
/*
 * Package for the stop mode power sequencer: register offsets, field
 * positions, reset values, stop levels and sequencer states.
 * Assumes a single 50 MHz clock domain and a plain strobe register port.
 */
package smps_pkg;

    localparam logic [3:0] ADDR_CTRL_TWO  = 4'h0;
    localparam logic [3:0] ADDR_CTRL_ONE  = 4'h1;
    localparam logic [3:0] ADDR_OPTION    = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;

    // Control two fields
    localparam int POS_PDC    = 0;
    localparam int POS_PARTIAL_POWER_DOWN_CONTROL   = 1;
    localparam int POS_ACK    = 2;
    localparam int POS_PARTIAL_POWER_DOWN_FLAG   = 3;
    localparam int POS_RATE   = 4;
    localparam int POS_OSCST  = 7;
    // Control one fields
    localparam int POS_LOW_VOLTAGE_DETECT_ENABLE   = 0;
    localparam int POS_LOW_VOLTAGE_DETECT_STOP_ENABLE  = 1;
    localparam int POS_DBGEN  = 2;
    // Option fields
    localparam int POS_STOP_ALLOW_OPTION  = 0;

    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_OPTION   = 8'h00;

    // Self-clocked wake source period, about 1 kHz
    localparam int WAKE_TICK_US  = 1000;
    localparam int CLOCK_MHZ     = 50;
    localparam int WAKE_TICK_CYC = WAKE_TICK_US * CLOCK_MHZ;

    typedef enum logic [1:0] {
        SMPS_LVL_RUN   = 2'b00,
        SMPS_LVL_DEEP  = 2'b01,
        SMPS_LVL_MID   = 2'b10,
        SMPS_LVL_SHALL = 2'b11
    } smps_level_t;

    typedef enum logic [2:0] {
        SMPS_ST_RUN    = 3'b000,
        SMPS_ST_STOP   = 3'b001,
        SMPS_ST_LVWAIT = 3'b010,
        SMPS_ST_WAKE   = 3'b011
    } smps_state_t;

    typedef struct packed {
        logic       regulator_standby;
        logic       converter_standby;
        logic       core_power_off;
        logic       ram_power_off;
        logic       clock_module_standby;
        logic       osc_halt;
        logic       sys_clock_gate;
        logic       debug_clock_on;
        logic       pin_latch;
        logic       pin_force_reset;
    } smps_power_t;

    typedef struct packed {
        logic       por_request;
        logic       illegal_op_reset;
        logic       irq_vector;
        logic       kbi_vector;
        logic       rti_vector;
        logic       debug_wake;
        logic       debug_error;
    } smps_event_t;

endpackage : smps_pkg

/* rtl/smps_sequencer.sv */
/*
 * Stop mode power sequencer: decodes the stop level, drives power and
 * pin-latch controls, watches wake sources and raises the wake results.
 * Assumes the core pulses i_stop_exec for one cycle and that the
 * register port master never issues read and write together.
 */
// Summary of operation
// - POWER_DOWN_CONTROL set, PARTIAL_POWER_DOWN_CONTROL clear gives deepest level
// - Deepest exits only on reset or low irq
// - Deepest asserts LOW_VOLTAGE_DETECT, waits supply, then POR
// - Deepest forces all pins to reset state
// - POWER_DOWN_CONTROL and PARTIAL_POWER_DOWN_CONTROL set give middle level
// - Middle keeps only RAM, regulator standby
// - Middle latches pins until acknowledge written
// - Middle wakes on reset, low irq, timer
// - Timer rate zero disables timer wake
// - Middle wake is POR, pins stay latched
// - Middle wake sets flag until acknowledge
// - Released pins follow current port settings
// - POWER_DOWN_CONTROL clear gives shallowest, state retained
// - Shallowest wakes on reset, irq, keys, timer
// - Shallowest reset gives POR, else vectors
// - Debug enabled keeps debug clock, regulator
// - Debug enabled forces shallowest, clock active
// - Debug status commands error, background wakes
// - LOW_VOLTAGE_DETECT in stop keeps regulator, forces shallowest
// - Oscillator-in-stop keeps generators at shallowest level only (deepest and middle halt them), gates feed
// - Stop disallowed forces illegal opcode reset
`timescale 1ns/100ps

module smps_sequencer (
    input  wire logic                 i_clock,
    input  wire logic                 i_sys_rst,
    input  wire logic [3:0]           i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    input  wire logic                 i_stop_exec,
    input  wire logic                 i_reset_pin_n,
    input  wire logic                 i_irq_pin_n,
    input  wire logic                 i_irq_edge_high,
    input  wire logic [7:0]           i_kbi_pins,
    input  wire logic [7:0]           i_kbi_enable,
    input  wire logic                 i_supply_ok,
    input  wire logic                 i_dbg_status_cmd,
    input  wire logic                 i_dbg_background_cmd,
    output smps_pkg::smps_power_t     o_power,
    output smps_pkg::smps_event_t     o_event,
    output logic                      o_lvd_assert,
    output logic      [1:0]           o_level
);

    typedef struct packed {
        smps_pkg::smps_state_t  state;
        smps_pkg::smps_level_t  level;
        logic [7:0]             ctrl_two;
        logic [7:0]             ctrl_one;
        logic [7:0]             option;
        logic                   option_written;
        logic                   partial_power_down_flag;
        logic                   latched;
        logic [2:0]             irq_sync;
        logic [2:0]             reset_sync;
        logic [15:0]            tick;
        logic [7:0]             rdata;
        smps_pkg::smps_power_t  power;
        smps_pkg::smps_event_t  event_out;
        logic                   low_voltage_detect;
    } smps_st_t;

    smps_st_t st_ff;
    smps_st_t nxt_st;

    // Level select with debug and LOW_VOLTAGE_DETECT overrides toward the shallowest level
    function automatic smps_pkg::smps_level_t pick_level(input logic [7:0] c2,
                                                         input logic [7:0] c1);
        if (!c2[smps_pkg::POS_PDC] || c1[smps_pkg::POS_DBGEN]
            || (c1[smps_pkg::POS_LOW_VOLTAGE_DETECT_ENABLE] && c1[smps_pkg::POS_LOW_VOLTAGE_DETECT_STOP_ENABLE])) begin
            return smps_pkg::SMPS_LVL_SHALL;
        end else if (c2[smps_pkg::POS_PARTIAL_POWER_DOWN_CONTROL]) begin
            return smps_pkg::SMPS_LVL_MID;
        end else begin
            return smps_pkg::SMPS_LVL_DEEP;
        end
    endfunction

    logic [2:0] rate;
    logic       timer_on;
    logic       irq_low_stop;
    logic       irq_run;
    logic       rst_pin_stop;
    logic       kbi_hit;
    logic       timer_hit;
    logic       stopped;

    assign rate     = st_ff.ctrl_two[smps_pkg::POS_RATE +: 3];
    assign timer_on = (rate != 3'h0);
    assign stopped  = (st_ff.state == smps_pkg::SMPS_ST_STOP);
    // Raw pins while stopped, since no clock is assumed to be running
    assign irq_low_stop = stopped ? !i_irq_pin_n : 1'b0;
    assign rst_pin_stop = stopped ? !i_reset_pin_n : 1'b0;
    assign kbi_hit  = stopped && |(i_kbi_pins & i_kbi_enable);
    assign irq_run  = i_irq_edge_high ? (st_ff.irq_sync[1] && st_ff.irq_sync[2])
                                      : !(st_ff.irq_sync[1] || st_ff.irq_sync[2]);
    assign timer_hit = timer_on && (st_ff.tick == 16'h0);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.event_out = '0;
        nxt_st.rdata = 8'h00;
        nxt_st.irq_sync = {st_ff.irq_sync[1:0], i_irq_pin_n};
        nxt_st.reset_sync = {st_ff.reset_sync[1:0], i_reset_pin_n};

        // Wake tick counter reloads one full period; it also runs in run mode
        if (!timer_on || st_ff.tick == 16'h0) begin
            nxt_st.tick = 16'(smps_pkg::WAKE_TICK_CYC - 1);
        end else begin
            nxt_st.tick = st_ff.tick - 16'h1;
        end

        if (i_wr) begin
            if (i_addr == smps_pkg::ADDR_CTRL_TWO) begin
                nxt_st.ctrl_two = {i_wdata[7:4], 1'b0, 1'b0, i_wdata[1:0]};
                if (i_wdata[smps_pkg::POS_ACK]) begin
                    nxt_st.partial_power_down_flag    = 1'b0;
                    nxt_st.latched = 1'b0;
                end
            end else if (i_addr == smps_pkg::ADDR_CTRL_ONE) begin
                nxt_st.ctrl_one = i_wdata & 8'h07;
            end else if (i_addr == smps_pkg::ADDR_OPTION && !st_ff.option_written) begin
                nxt_st.option = i_wdata & 8'h01;
                nxt_st.option_written = 1'b1;
            end
        end
        if (i_rd) begin
            if (i_addr == smps_pkg::ADDR_CTRL_TWO) begin
                nxt_st.rdata = st_ff.ctrl_two;
                nxt_st.rdata[smps_pkg::POS_PARTIAL_POWER_DOWN_FLAG] = st_ff.partial_power_down_flag;
            end else if (i_addr == smps_pkg::ADDR_CTRL_ONE) begin
                nxt_st.rdata = st_ff.ctrl_one;
            end else if (i_addr == smps_pkg::ADDR_OPTION) begin
                nxt_st.rdata = st_ff.option;
            end else if (i_addr == smps_pkg::ADDR_STATUS) begin
                nxt_st.rdata = {4'h0, st_ff.latched, st_ff.state};
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end

        case (st_ff.state)
            smps_pkg::SMPS_ST_RUN: begin
                nxt_st.power = '0;
                nxt_st.power.pin_latch = st_ff.latched;
                nxt_st.level = smps_pkg::SMPS_LVL_RUN;
                nxt_st.low_voltage_detect = 1'b0;
                if (i_stop_exec) begin
                    if (!st_ff.option[smps_pkg::POS_STOP_ALLOW_OPTION]) begin
                        nxt_st.event_out.illegal_op_reset = 1'b1;
                    end else begin
                        nxt_st.level = pick_level(st_ff.ctrl_two, st_ff.ctrl_one);
                        nxt_st.state = smps_pkg::SMPS_ST_STOP;
                        nxt_st.power.sys_clock_gate = 1'b1;
                        nxt_st.power.osc_halt =
                            !st_ff.ctrl_two[smps_pkg::POS_OSCST];
                        nxt_st.power.converter_standby = 1'b1;
                        nxt_st.power.debug_clock_on =
                            st_ff.ctrl_one[smps_pkg::POS_DBGEN];
                        nxt_st.power.regulator_standby = !(st_ff.ctrl_one[smps_pkg::POS_DBGEN]
                            || (st_ff.ctrl_one[smps_pkg::POS_LOW_VOLTAGE_DETECT_ENABLE]
                                && st_ff.ctrl_one[smps_pkg::POS_LOW_VOLTAGE_DETECT_STOP_ENABLE]));
                        nxt_st.power.clock_module_standby =
                            !st_ff.ctrl_one[smps_pkg::POS_DBGEN];
                        if (nxt_st.level == smps_pkg::SMPS_LVL_DEEP) begin
                            nxt_st.power.core_power_off  = 1'b1;
                            nxt_st.power.ram_power_off   = 1'b1;
                            nxt_st.power.pin_force_reset = 1'b1;
                            nxt_st.power.osc_halt        = 1'b1;
                            nxt_st.low_voltage_detect = 1'b1;
                        end else if (nxt_st.level == smps_pkg::SMPS_LVL_MID) begin
                            nxt_st.power.core_power_off = 1'b1;
                            nxt_st.power.pin_latch      = 1'b1;
                            nxt_st.power.osc_halt       = 1'b1;
                            nxt_st.latched = 1'b1;
                        end
                    end
                end
            end
            smps_pkg::SMPS_ST_STOP: begin
                if (i_dbg_status_cmd) begin
                    nxt_st.event_out.debug_error = 1'b1;
                end
                if (st_ff.level == smps_pkg::SMPS_LVL_DEEP) begin
                    if (rst_pin_stop || irq_low_stop) begin
                        nxt_st.state = smps_pkg::SMPS_ST_LVWAIT;
                    end
                end else if (st_ff.level == smps_pkg::SMPS_LVL_MID) begin
                    if (rst_pin_stop || irq_low_stop || timer_hit) begin
                        nxt_st.state = smps_pkg::SMPS_ST_WAKE;
                    end
                end else begin
                    if (rst_pin_stop) begin
                        nxt_st.event_out.por_request = 1'b1;
                        nxt_st.state = smps_pkg::SMPS_ST_WAKE;
                    end else if (i_dbg_background_cmd && st_ff.ctrl_one[smps_pkg::POS_DBGEN]) begin
                        nxt_st.event_out.debug_wake = 1'b1;
                        nxt_st.state = smps_pkg::SMPS_ST_WAKE;
                    end else if (irq_low_stop || kbi_hit || timer_hit) begin
                        nxt_st.event_out.irq_vector = irq_low_stop;
                        nxt_st.event_out.kbi_vector = !irq_low_stop && kbi_hit;
                        nxt_st.event_out.rti_vector = !irq_low_stop && !kbi_hit;
                        nxt_st.state = smps_pkg::SMPS_ST_WAKE;
                    end
                end
            end
            smps_pkg::SMPS_ST_LVWAIT: begin
                if (i_supply_ok) begin
                    nxt_st.low_voltage_detect = 1'b0;
                    nxt_st.event_out.por_request = 1'b1;
                    nxt_st.state = smps_pkg::SMPS_ST_WAKE;
                end
            end
            default: begin
                if (st_ff.level == smps_pkg::SMPS_LVL_MID) begin
                    nxt_st.event_out.por_request = 1'b1;
                    nxt_st.partial_power_down_flag = 1'b1;
                end
                // Both power-down exits restart the controls as from power-on
                if (st_ff.level == smps_pkg::SMPS_LVL_MID
                    || st_ff.level == smps_pkg::SMPS_LVL_DEEP) begin
                    nxt_st.ctrl_two = smps_pkg::RST_CTRL_TWO;
                    nxt_st.ctrl_one = smps_pkg::RST_CTRL_ONE;
                    nxt_st.option   = smps_pkg::RST_OPTION;
                    nxt_st.option_written = 1'b0;
                end
                nxt_st.state = smps_pkg::SMPS_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_ff <= '0;
            st_ff.irq_sync <= 3'h7;
            st_ff.reset_sync <= 3'h7;
            st_ff.ctrl_two <= smps_pkg::RST_CTRL_TWO;
            st_ff.ctrl_one <= smps_pkg::RST_CTRL_ONE;
            st_ff.option <= smps_pkg::RST_OPTION;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata      = st_ff.rdata;
    assign o_power      = st_ff.power;
    assign o_event      = st_ff.event_out;
    assign o_lvd_assert = st_ff.low_voltage_detect;
    assign o_level      = st_ff.level;

    deep_lvd_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        st_ff.state == smps_pkg::SMPS_ST_LVWAIT |-> o_lvd_assert)
        else $error("lvd not held while waiting for supply");
    deep_pins_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_level == smps_pkg::SMPS_LVL_DEEP |-> o_power.pin_force_reset)
        else $error("pins not forced in deepest level");
    mid_latch_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_level == smps_pkg::SMPS_LVL_MID |-> o_power.pin_latch && !o_power.ram_power_off)
        else $error("middle level latch or ram wrong");
    illegal_stop_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        st_ff.state == smps_pkg::SMPS_ST_RUN && i_stop_exec
        && !st_ff.option[smps_pkg::POS_STOP_ALLOW_OPTION] |=> o_event.illegal_op_reset
        && st_ff.state == smps_pkg::SMPS_ST_RUN)
        else $error("disallowed stop not refused");
    dbg_override_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        st_ff.state == smps_pkg::SMPS_ST_RUN && i_stop_exec
        && st_ff.option[smps_pkg::POS_STOP_ALLOW_OPTION]
        && st_ff.ctrl_one[smps_pkg::POS_DBGEN] |=> o_level == smps_pkg::SMPS_LVL_SHALL
        && o_power.debug_clock_on && !o_power.regulator_standby)
        else $error("debug stop not shallow");
    lvd_override_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        st_ff.state == smps_pkg::SMPS_ST_RUN && i_stop_exec
        && st_ff.option[smps_pkg::POS_STOP_ALLOW_OPTION] && st_ff.ctrl_one[smps_pkg::POS_LOW_VOLTAGE_DETECT_ENABLE]
        && st_ff.ctrl_one[smps_pkg::POS_LOW_VOLTAGE_DETECT_STOP_ENABLE] |=> o_level == smps_pkg::SMPS_LVL_SHALL
        && !o_power.regulator_standby)
        else $error("voltage detect stop not shallow");
    ack_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_wr && i_addr == smps_pkg::ADDR_CTRL_TWO && i_wdata[smps_pkg::POS_ACK]
        && st_ff.state == smps_pkg::SMPS_ST_RUN |=> !st_ff.partial_power_down_flag ##1 !o_power.pin_latch)
        else $error("acknowledge did not release");
    mid_wake_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        st_ff.state == smps_pkg::SMPS_ST_WAKE && st_ff.level == smps_pkg::SMPS_LVL_MID
        |=> st_ff.partial_power_down_flag && o_event.por_request)
        else $error("middle wake missed flag");
    mid_nokey_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        stopped && st_ff.level == smps_pkg::SMPS_LVL_MID |=> !o_event.kbi_vector)
        else $error("keyboard woke middle level");
    deep_hold_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        stopped && st_ff.level == smps_pkg::SMPS_LVL_DEEP && i_reset_pin_n && i_irq_pin_n
        |=> st_ff.state == smps_pkg::SMPS_ST_STOP)
        else $error("deepest level left without wake pin");
    timer_off_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        stopped && st_ff.ctrl_two[smps_pkg::POS_RATE +: 3] == 3'h0 |=> !o_event.rti_vector)
        else $error("timer fired while disabled");
    deep_cov: cover property (@(posedge i_clock) st_ff.state == smps_pkg::SMPS_ST_LVWAIT);
    mid_cov: cover property (@(posedge i_clock) st_ff.partial_power_down_flag);
    kbi_cov: cover property (@(posedge i_clock) o_event.kbi_vector);
    rti_cov: cover property (@(posedge i_clock) o_event.rti_vector);
    dbg_cov: cover property (@(posedge i_clock) o_event.debug_wake);

endmodule // smps_sequencer

/* tb/smps_core_model.sv */
/*
 * Far-side model of the sequencer: the core that pulses stop, plus the
 * wake pins and the supply monitor level.
 * Assumes one clock; every change is made just after a rising edge.
 */
`timescale 1ns/100ps

module smps_core_model (
    input  wire logic       i_clock,
    output logic            o_stop_exec,
    output logic            o_reset_pin_n,
    output logic            o_irq_pin_n,
    output logic [7:0]      o_kbi_pins,
    output logic            o_supply_ok
);
    initial begin
        o_stop_exec   = 1'b0;
        o_reset_pin_n = 1'b1;
        o_irq_pin_n   = 1'b1;
        o_kbi_pins    = 8'h00;
        o_supply_ok   = 1'b1;
    end

    task automatic stop_now();
        @(posedge i_clock);
        o_stop_exec <= 1'b1;
        @(posedge i_clock);
        o_stop_exec <= 1'b0;
    endtask

    // Pins have pull-ups, so a released pin returns high
    task automatic pin_low(input int which, input int cycles);
        @(posedge i_clock);
        if (which == 0) begin
            o_irq_pin_n <= 1'b0;
        end else begin
            o_reset_pin_n <= 1'b0;
        end
        repeat (cycles) @(posedge i_clock);
        o_irq_pin_n   <= 1'b1;
        o_reset_pin_n <= 1'b1;
    endtask

    task automatic set_kbi(input logic [7:0] v);
        @(posedge i_clock);
        o_kbi_pins <= v;
    endtask

    task automatic set_supply(input logic v);
        @(posedge i_clock);
        o_supply_ok <= v;
    endtask
endmodule // smps_core_model

/* tb/stop_mode_power_sequencer_tb_top.sv */
/*
 * Self-checking bench for the stop mode power sequencer.
 * Assumes the core model in smps_core_model and a 50 MHz clock.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module stop_mode_power_sequencer_tb_top;
    // Bit positions inside the packed event struct, first field is the msb
    localparam int EV_POR = 6, EV_ILL = 5, EV_IRQ = 4, EV_KBI = 3;
    localparam int EV_RTI = 2, EV_DWAKE = 1, EV_DERR = 0;

    logic                    clock, sys_rst, wr, rd, dbg_stat, dbg_bg, irq_edge;
    logic [3:0]              addr;
    logic [7:0]              wdata, rdata, kbi_en, keyboard_wake_pins;
    logic                    stop_exec, rst_n, irq_n, supply_ok, low_voltage_detect;
    logic [1:0]              level;
    smps_pkg::smps_power_t   pw;
    smps_pkg::smps_event_t   ev;
    int                      err_count = 0;
    int                      n_checks = 0;

    smps_core_model u_core (.i_clock(clock), .o_stop_exec(stop_exec), .o_reset_pin_n(rst_n),
        .o_irq_pin_n(irq_n), .o_kbi_pins(keyboard_wake_pins), .o_supply_ok(supply_ok));

    smps_sequencer u_dut (.i_clock(clock), .i_sys_rst(sys_rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_stop_exec(stop_exec),
        .i_reset_pin_n(rst_n), .i_irq_pin_n(irq_n), .i_irq_edge_high(irq_edge),
        .i_kbi_pins(keyboard_wake_pins), .i_kbi_enable(kbi_en), .i_supply_ok(supply_ok),
        .i_dbg_status_cmd(dbg_stat), .i_dbg_background_cmd(dbg_bg), .o_power(pw),
        .o_event(ev), .o_lvd_assert(low_voltage_detect), .o_level(level));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Event outputs are one-cycle pulses, so every cycle is looked at
    task automatic wait_ev(input int idx, input int lim, output logic hit);
        hit = 1'b0;
        for (int k = 0; k < lim && !hit; k++) begin
            @(posedge clock);
            #1 if (ev[idx] === 1'b1) hit = 1'b1;
        end
    endtask

    // Option write is write-once until a middle or deepest wake clears it, so rewriting it is needed after such a wake and harmless otherwise
    task automatic go_stop(input logic [7:0] c2);
        reg_wr(smps_pkg::ADDR_OPTION, 8'h01);
        reg_wr(smps_pkg::ADDR_CTRL_TWO, c2);
        u_core.stop_now();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic dbg_pulse(input int which);
        @(posedge clock);
        if (which == 0) dbg_stat <= 1'b1;
        else dbg_bg <= 1'b1;
        @(posedge clock);
        dbg_stat <= 1'b0;
        dbg_bg <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #(90000 * 20);
        err_count++;
        wrap_up();
    end

    initial begin
        logic [7:0] d;
        logic       hit;
        sys_rst = 1'b1;
        {wr, rd, dbg_stat, dbg_bg, irq_edge, addr, wdata, kbi_en} = '0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        reg_rd(smps_pkg::ADDR_CTRL_TWO, d); `CHK(d, smps_pkg::RST_CTRL_TWO)
        reg_rd(smps_pkg::ADDR_CTRL_ONE, d); `CHK(d, smps_pkg::RST_CTRL_ONE)
        reg_rd(smps_pkg::ADDR_OPTION, d); `CHK(d, smps_pkg::RST_OPTION)
        reg_rd(4'h9, d); `CHK(d, 8'h00)
        // Stop while stop is not allowed
        fork u_core.stop_now(); wait_ev(EV_ILL, 6, hit); join
        `CHK(hit, 1'b1)
        `CHK(level, 2'h0)
        reg_wr(smps_pkg::ADDR_OPTION, 8'h01);
        reg_wr(smps_pkg::ADDR_OPTION, 8'h00);
        reg_rd(smps_pkg::ADDR_OPTION, d); `CHK(d[0], 1'b1)
        // Middle level: latch, keyboard ignored, irq wake, flag and acknowledge
        @(posedge clock) kbi_en <= 8'hff;
        go_stop(8'h03);
        `CHK(level, 2'h2)
        `CHK({pw.core_power_off, pw.ram_power_off, pw.regulator_standby}, 3'b101)
        `CHK(pw.converter_standby, 1'b1)
        `CHK(pw.pin_latch, 1'b1)
        fork u_core.set_kbi(8'hff); wait_ev(EV_KBI, 10, hit); join
        `CHK(hit, 1'b0)
        `CHK(level, 2'h2)
        u_core.set_kbi(8'h00);
        fork u_core.pin_low(0, 3); wait_ev(EV_POR, 20, hit); join
        `CHK(hit, 1'b1)
        #1 `CHK(pw.pin_latch, 1'b1)
        reg_rd(smps_pkg::ADDR_STATUS, d); `CHK(d, 8'h08)
        reg_rd(smps_pkg::ADDR_CTRL_TWO, d); `CHK(d, 8'h08)
        reg_wr(smps_pkg::ADDR_OPTION, 8'h01);
        reg_wr(smps_pkg::ADDR_CTRL_TWO, 8'h04);
        repeat (2) @(posedge clock);
        #1 `CHK(pw.pin_latch, 1'b0)
        reg_rd(smps_pkg::ADDR_CTRL_TWO, d); `CHK(d, 8'h00)
        // Deepest level: exit held until the supply recovers
        u_core.set_supply(1'b0);
        irq_edge <= 1'b1;
        go_stop(8'h01);
        `CHK(level, 2'h1)
        `CHK({pw.core_power_off, pw.ram_power_off, pw.regulator_standby}, 3'b111)
        `CHK(low_voltage_detect, 1'b1)
        `CHK(pw.pin_force_reset, 1'b1)
        fork u_core.pin_low(0, 3); wait_ev(EV_POR, 20, hit); join
        `CHK(hit, 1'b0)
        fork u_core.set_supply(1'b1); wait_ev(EV_POR, 20, hit); join
        `CHK(hit, 1'b1)
        repeat (2) @(posedge clock);
        irq_edge <= 1'b0;
        #1 `CHK(low_voltage_detect, 1'b0)
        reg_rd(smps_pkg::ADDR_CTRL_TWO, d); `CHK(d, smps_pkg::RST_CTRL_TWO)
        // Shallowest level with oscillator kept, woken by keyboard
        @(posedge clock) kbi_en <= 8'h10;
        go_stop(8'h80);
        `CHK(level, 2'h3)
        `CHK({pw.osc_halt, pw.sys_clock_gate}, 2'b01)
        `CHK({pw.ram_power_off, pw.pin_latch, pw.core_power_off}, 3'b000)
        fork u_core.set_kbi(8'h10); wait_ev(EV_KBI, 20, hit); join
        `CHK(hit, 1'b1)
        u_core.set_kbi(8'h00);
        reg_rd(smps_pkg::ADDR_CTRL_TWO, d); `CHK(d, 8'h80)
        // Shallowest level woken by irq, then by the reset pin
        go_stop(8'h00);
        `CHK(pw.osc_halt, 1'b1)
        fork u_core.pin_low(0, 3); wait_ev(EV_IRQ, 20, hit); join
        `CHK(hit, 1'b1)
        go_stop(8'h00);
        fork u_core.pin_low(1, 3); wait_ev(EV_POR, 20, hit); join
        `CHK(hit, 1'b1)
        // Debug entry enabled turns a deepest request into shallowest
        reg_wr(smps_pkg::ADDR_CTRL_ONE, 8'h04);
        go_stop(8'h01);
        `CHK(level, 2'h3)
        `CHK(pw.clock_module_standby, 1'b0)
        `CHK({pw.debug_clock_on, pw.regulator_standby, pw.sys_clock_gate}, 3'b101)
        fork dbg_pulse(0); wait_ev(EV_DERR, 6, hit); join
        `CHK(hit, 1'b1)
        `CHK(level, 2'h3)
        fork dbg_pulse(1); wait_ev(EV_DWAKE, 6, hit); join
        `CHK(hit, 1'b1)
        // Voltage detect kept in stop turns a middle request into shallowest
        reg_wr(smps_pkg::ADDR_CTRL_ONE, 8'h03);
        go_stop(8'h03);
        `CHK(level, 2'h3)
        `CHK(pw.regulator_standby, 1'b0)
        fork u_core.pin_low(0, 3); wait_ev(EV_IRQ, 20, hit); join
        `CHK(hit, 1'b1)
        // Periodic wake from the shallowest level, about one tick
        reg_wr(smps_pkg::ADDR_CTRL_ONE, 8'h00);
        go_stop(8'h10);
        wait_ev(EV_RTI, 70000, hit);
        `CHK(hit, 1'b1)
        wrap_up();
    end
endmodule // stop_mode_power_sequencer_tb_top
